// [aess_pkg.sv]
// aess_pkg: shared constants for the alarm emergency-stop sequencer
// assumes a 32-bit apb register bus and a 10 MHz core clock
package aess_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG = 8'h00; // sequence select, alarm clear
  localparam logic [7:0] OFS_TRQ = 8'h04; // emergency and normal torque
  localparam logic [7:0] OFS_OSL = 8'h08; // overspeed levels
  localparam logic [7:0] OFS_TMO = 8'h0C; // emergency stop timeout
  localparam logic [7:0] OFS_BRK = 8'h10; // brake delay and threshold
  localparam logic [7:0] OFS_FLG = 8'h14; // sticky alarm causes, w1c
  localparam logic [7:0] OFS_STA = 8'h18; // live sequencer state

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_CLR_BIT  = 16;
  localparam int HI_FIELD_LSB = 16; // upper field of trq, osl, brk
  localparam int FLG_OS1      = 0;
  localparam int FLG_OS2      = 1;
  localparam int FLG_TMO      = 2;
  localparam int FLG_EMG      = 3;
  localparam int FLG_NEMG     = 4;
  localparam int FLG_W        = 5;

  // ----------------------------------------------------------------
  // reset values and fixed levels
  // ----------------------------------------------------------------
  localparam logic [8:0]  RST_NORM_TRQ = 9'h12C;  // 300 percent
  localparam logic [11:0] RST_BRK_THR  = 12'h01E; // 30 r/min
  localparam logic [15:0] STOP_RPM     = 16'h001E; // stopped at or below
  localparam logic [2:0]  EMG_SEQ_MIN  = 3'h4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int MS_NS  = 1000000;
  localparam int CLK_NS = 100;
  localparam int CYC_PER_MS_DEF = MS_NS / CLK_NS;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN,
    ST_PRE,
    ST_ESTOP,
    ST_STOPB,
    ST_ALARM
  } aess_state_t;

endpackage

// [aess_pin_sync.sv]
// aess_pin_sync: three-stage synchroniser with agreement filter
// assumes an asynchronous pin input and the core clock
`timescale 1ns/1ps
module aess_pin_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // pin side
  input  wire logic pin_in,
  // core side
  output logic      level_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } aess_sync_t;

  aess_sync_t r_reg;
  aess_sync_t r_next;

  // shift chain; output follows once stages two and three agree
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = pin_in;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    if (r_reg.s2 == r_reg.s3) begin
      r_next.lvl = r_reg.s3;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level_out = r_reg.lvl;

endmodule

// [aess_top.sv]
// aess_top: alarm-time stop sequencer with apb register file
// assumes speed and alarm inputs from logic on ref_clk, forced alarm
// from a pin
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module aess_top import aess_pkg::*; #(
  parameter int          CYC_PER_MS   = CYC_PER_MS_DEF,
  parameter logic [15:0] INT_OS_LEVEL = 16'h1770
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // drive status inputs
  input  wire logic [15:0] motor_speed,
  input  wire logic        emg_alarm_in,
  input  wire logic        nonemg_alarm_in,
  input  wire logic        forced_alarm_pin,
  input  wire logic        servo_on_cmd,
  input  wire logic [31:0] host_cmd_pos,
  input  wire logic [31:0] fb_pos,
  // drive controls
  output logic [8:0]       torque_limit,
  output logic             current_off,
  output logic             dynamic_brake,
  output logic             brake_release,
  output logic             alarm_state,
  output logic             servo_on_status,
  output logic             deviation_clear,
  output logic [31:0]      cmd_pos
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int PRE_W = $clog2(CYC_PER_MS);
  localparam logic [PRE_W-1:0] PRE_MAX = PRE_W'(CYC_PER_MS - 1);

  typedef struct packed {
    aess_state_t      st;
    logic [2:0]       seq;
    logic [8:0]       etl;
    logic [8:0]       ntl;
    logic [14:0]      lvl1;
    logic [14:0]      lvl2;
    logic [9:0]       tmo;
    logic [14:0]      bdly;
    logic [11:0]      bthr;
    logic [FLG_W-1:0] flg;
    logic [PRE_W-1:0] pre;
    logic [14:0]      ms;
    logic             brk_on;
    logic             son;
    logic [8:0]       trq;
    logic [31:0]      pos;
    logic [31:0]      rdata;
  } aess_regs_t;

  aess_regs_t r_reg;
  aess_regs_t r_next;

  logic             forced_alarm;
  logic             os1;
  logic             os2;
  logic             emg_ev;
  logic             non_ev;
  logic             stopped;
  logic             tmo_ev;
  logic             wr;
  logic [FLG_W-1:0] flg_clr;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // zero setting selects the motor-limited internal level
  function automatic logic [15:0] eff_lvl(input logic [14:0] lvl);
    eff_lvl = (lvl == 15'h0000) ? INT_OS_LEVEL : {1'b0, lvl};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CFG) || (a == OFS_TRQ) || (a == OFS_OSL) ||
             (a == OFS_TMO) || (a == OFS_BRK) || (a == OFS_FLG) ||
             (a == OFS_STA);
  endfunction

  // ----------------------------------------------------------------
  // forced alarm pin
  // ----------------------------------------------------------------
  aess_pin_sync u_forced_sync (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pin_in    (forced_alarm_pin),
    .level_out (forced_alarm)
  );

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  assign os1     = motor_speed > eff_lvl(r_reg.lvl1);
  assign os2     = motor_speed > eff_lvl(r_reg.lvl2);
  assign emg_ev  = emg_alarm_in | forced_alarm | os1;
  assign non_ev  = nonemg_alarm_in | os2;
  assign stopped = motor_speed <= STOP_RPM;
  assign tmo_ev  = (r_reg.st == ST_ESTOP) && !non_ev && !stopped &&
                   (r_reg.ms >= {5'h00, r_reg.tmo});
  assign wr      = psel & penable & pwrite;
  assign flg_clr = (wr && paddr == OFS_FLG) ? pwdata[FLG_W-1:0] : '0;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    r_next     = r_reg;
    r_next.son = servo_on_cmd;

    // millisecond timer runs from the alarm onward
    if (r_reg.st == ST_RUN) begin
      r_next.pre = '0;
      r_next.ms  = '0;
    end else if (r_reg.pre == PRE_MAX) begin
      r_next.pre = '0;
      if (r_reg.ms != 15'h7FFF) begin
        r_next.ms = r_reg.ms + 15'h0001;
      end
    end else begin
      r_next.pre = r_reg.pre + PRE_W'(1);
    end

    // sticky causes, a new event beats a clear
    r_next.flg = (r_reg.flg & ~flg_clr) |
                 {nonemg_alarm_in, emg_ev, tmo_ev, os2, os1};

    // sequencer
    unique case (r_reg.st)
      ST_RUN: begin
        if (non_ev) begin
          r_next.st = ST_STOPB;
        end else if (emg_ev) begin
          if (r_reg.seq < EMG_SEQ_MIN) begin
            r_next.st = ST_STOPB;
          end else if (r_reg.tmo == 10'h000) begin
            r_next.st = ST_ALARM;
          end else begin
            r_next.st = ST_PRE;
          end
        end
      end
      ST_PRE: begin
        r_next.st = non_ev ? ST_STOPB : ST_ESTOP;
      end
      ST_ESTOP: begin
        if (non_ev || stopped || tmo_ev) begin
          r_next.st = ST_ALARM;
        end
      end
      ST_STOPB: begin
        if (stopped) begin
          r_next.st = ST_ALARM;
        end
      end
      ST_ALARM: begin
        if (wr && paddr == OFS_CFG && pwdata[CFG_CLR_BIT] && stopped) begin
          r_next.st = ST_RUN;
        end
      end
    endcase

    // brake engage latch
    if (r_reg.st == ST_RUN) begin
      r_next.brk_on = 1'b0;
    end else if (motor_speed < {4'h0, r_reg.bthr}) begin
      r_next.brk_on = 1'b1;
    end else if (r_reg.st == ST_STOPB || r_reg.st == ST_ALARM) begin
      r_next.brk_on = 1'b1;
    end else if (r_reg.bdly <= {5'h00, r_reg.tmo} &&
                 r_reg.ms >= r_reg.bdly) begin
      r_next.brk_on = 1'b1;
    end

    // torque limit, emergency value only while stopping
    if (r_reg.st == ST_ESTOP && r_reg.etl != 9'h000) begin
      r_next.trq = r_reg.etl;
    end else begin
      r_next.trq = r_reg.ntl;
    end

    // command position follows feedback while stopping
    r_next.pos = (r_reg.st == ST_RUN) ? host_cmd_pos : fb_pos;

    // register writes take effect at the access edge
    if (wr) begin
      unique case (paddr)
        OFS_CFG: r_next.seq = pwdata[2:0];
        OFS_TRQ: begin
          r_next.etl = pwdata[8:0];
          r_next.ntl = pwdata[HI_FIELD_LSB +: 9];
        end
        OFS_OSL: begin
          r_next.lvl1 = pwdata[14:0];
          r_next.lvl2 = pwdata[HI_FIELD_LSB +: 15];
        end
        OFS_TMO: r_next.tmo = pwdata[9:0];
        OFS_BRK: begin
          r_next.bdly = pwdata[14:0];
          r_next.bthr = pwdata[HI_FIELD_LSB +: 12];
        end
        default: ;
      endcase
    end

    // read data is captured in the setup phase
    if (psel && !penable) begin
      unique case (paddr)
        OFS_CFG: r_next.rdata = {29'h0, r_reg.seq};
        OFS_TRQ: r_next.rdata = {7'h0, r_reg.ntl, 7'h0, r_reg.etl};
        OFS_OSL: r_next.rdata = {1'b0, r_reg.lvl2, 1'b0, r_reg.lvl1};
        OFS_TMO: r_next.rdata = {22'h0, r_reg.tmo};
        OFS_BRK: r_next.rdata = {4'h0, r_reg.bthr, 1'b0, r_reg.bdly};
        OFS_FLG: r_next.rdata = {27'h0, r_reg.flg};
        OFS_STA: r_next.rdata = {26'h0, current_off, dynamic_brake,
                                 brake_release, r_reg.st};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_reg <= '{st: ST_RUN, ntl: RST_NORM_TRQ, bthr: RST_BRK_THR,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // bus answers in the access phase with no wait state
  assign prdata  = r_reg.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & !mapped(paddr);

  // drive controls decoded from sequencer state; servo status is the registered command
  assign current_off     = (r_reg.st == ST_STOPB) ||
                           (r_reg.st == ST_ALARM);
  assign alarm_state     = r_reg.st == ST_ALARM;
  assign deviation_clear = r_reg.st != ST_RUN;
  assign servo_on_status = r_reg.son;
  assign torque_limit    = r_reg.trq;
  assign cmd_pos         = r_reg.pos;
  assign brake_release   = (r_reg.st == ST_RUN) ? r_reg.son :
                           !r_reg.brk_on;

  // odd sequence values free-run mid-stop, bit one frees post-stop
  always_comb begin
    unique case (r_reg.st)
      ST_STOPB: dynamic_brake = !r_reg.seq[0];
      ST_ALARM: dynamic_brake = stopped ? !r_reg.seq[1]
                                        : !r_reg.seq[0];
      default:  dynamic_brake = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  seq_gate_a: assert property (
    $rose(r_reg.st == ST_PRE) |-> $past(r_reg.seq) >= EMG_SEQ_MIN)
    else $error("emergency stop entered with low sequence value");

  stop_b_db_a: assert property (
    r_reg.st == ST_STOPB |-> dynamic_brake == !r_reg.seq[0])
    else $error("operation b brake does not match sequence");

  emg_torque_a: assert property (
    (r_reg.st == ST_ESTOP && r_reg.etl != 9'h000)
      |=> torque_limit == $past(r_reg.etl))
    else $error("emergency torque limit not applied");

  os1_flag_a: assert property (
    os1 |=> r_reg.flg[FLG_OS1])
    else $error("first overspeed not latched");

  os2_stop_a: assert property (
    (r_reg.st == ST_RUN && os2) |=> current_off && !alarm_state)
    else $error("second overspeed did not cut current");

  tmo_alarm_a: assert property (
    tmo_ev |=> alarm_state && r_reg.flg[FLG_TMO])
    else $error("emergency stop timeout not enforced");

  zero_tmo_a: assert property (
    (r_reg.st == ST_RUN && emg_ev && !non_ev && r_reg.tmo == 10'h000 &&
     r_reg.seq >= EMG_SEQ_MIN) |=> alarm_state)
    else $error("zero timeout did not force alarm");

  abort_emg_a: assert property (
    (r_reg.st == ST_ESTOP && non_ev) |=> alarm_state)
    else $error("non-emergency alarm did not abort stop");

  pre_torque_a: assert property (
    r_reg.st == ST_PRE |=> torque_limit == $past(r_reg.ntl))
    else $error("normal torque limit not kept before stop");

  brk_speed_a: assert property (
    (r_reg.st != ST_RUN && motor_speed < {4'h0, r_reg.bthr})
      |=> ##1 !brake_release || r_reg.st == ST_RUN)
    else $error("brake not engaged at low speed");

endmodule

// [aess_host_model.sv]
// aess_host_model: host motion controller ramping position commands
// assumes the core clock domain and a drive-side stop notification
`timescale 1ns/1ps
module aess_host_model #(
  parameter int CYC_PER_MS = 10
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // control from bench and drive
  input  wire logic        enable,
  input  wire logic        alarm_notice,
  // commands to drive
  output logic             servo_on_cmd,
  output logic [31:0]      host_cmd_pos
);
  int hold_cnt;

  // ramp position; keep commanding 4 ms past a stop notice
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      servo_on_cmd <= 1'b0;
      host_cmd_pos <= 32'h0;
      hold_cnt <= 0;
    end else begin
      servo_on_cmd <= enable;
      if (!alarm_notice) begin
        hold_cnt <= 0;
      end else if (hold_cnt < 4 * CYC_PER_MS) begin
        hold_cnt <= hold_cnt + 1;
      end
      if (enable && (!alarm_notice || hold_cnt < 4 * CYC_PER_MS)) begin
        host_cmd_pos <= host_cmd_pos + 32'h10;
      end
    end
  end
endmodule

// [tb.sv]
// tb: self-checking bench for the alarm stop sequencer
// assumes aess_top and aess_host_model; 1 ms shortened to 10 cycles
`timescale 1ns/1ps
module tb import aess_pkg::*; ;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int CPM = 10;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, host_cmd_pos, fb_pos, cmd_pos, rd_q;
  logic [15:0] motor_speed;
  logic        emg_alarm_in, nonemg_alarm_in, forced_alarm_pin, host_en;
  logic        servo_on_cmd, current_off, dynamic_brake, brake_release;
  logic        alarm_state, servo_on_status, deviation_clear, rd_err;
  logic [8:0]  torque_limit;
  int          err_count, n_checks;

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  aess_top #(.CYC_PER_MS(CPM)) uut (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .motor_speed, .emg_alarm_in, .nonemg_alarm_in,
    .forced_alarm_pin, .servo_on_cmd, .host_cmd_pos, .fb_pos,
    .torque_limit, .current_off, .dynamic_brake, .brake_release,
    .alarm_state, .servo_on_status, .deviation_clear, .cmd_pos);
  aess_host_model #(.CYC_PER_MS(CPM)) host (
    .ref_clk, .rst_n, .enable(host_en), .alarm_notice(deviation_clear),
    .servo_on_cmd, .host_cmd_pos);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t apb no ready", $time);
      final_report();
    end
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string m);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e, m);
  endtask

  task automatic cfg(input logic [31:0] seq, trq, osl, tmo, brk);
    apb(1'b1, OFS_CFG, seq);
    apb(1'b1, OFS_TRQ, trq);
    apb(1'b1, OFS_OSL, osl);
    apb(1'b1, OFS_TMO, tmo);
    apb(1'b1, OFS_BRK, brk);
  endtask

  // one-cycle alarm pulse, emergency or not
  task automatic pulse(input bit ne);
    @(posedge ref_clk);
    {nonemg_alarm_in, emg_alarm_in} <= ne ? 2'b10 : 2'b01;
    @(posedge ref_clk);
    {nonemg_alarm_in, emg_alarm_in} <= 2'b00;
    #1;
  endtask

  // stop the motor, clear alarm and flags
  task automatic clr(input string name);
    motor_speed <= 16'h0;
    cyc(4);
    apb(1'b1, OFS_CFG, 32'h0001_0000);
    apb(1'b1, OFS_FLG, 32'h0000_001F);
    rd(OFS_FLG, 32'h0, "flags clear");
    chk(32'(alarm_state), 32'h0, "cleared");
    $display("done: %s", name);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(OFS_TRQ, 32'h012C_0000, "trq reset");
    rd(OFS_BRK, 32'h001E_0000, "brk reset");
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(rd_err), 32'h1, "unmapped");
    chk(32'(torque_limit), 32'(RST_NORM_TRQ), "trq out");
    chk(32'(brake_release), 32'h1, "brake open");
    chk(32'(servo_on_status), 32'h1, "servo on");
    chk(32'(deviation_clear), 32'h0, "no dev clear");
    host_en <= 1'b0;
    cyc(3);
    chk(32'(servo_on_status), 32'h0, "servo off");
    host_en <= 1'b1;
    cyc(3);
    $display("done: reset");
  endtask

  task automatic t_estop();
    cfg(32'h4, 32'h012C_0096, 32'h0, 32'h5, 32'h001E_0000);
    motor_speed <= 16'h03E8;
    pulse(1'b0);
    chk(32'(torque_limit), 32'h12C, "pre torque");
    cyc(4);
    chk(32'(torque_limit), 32'h096, "estop torque");
    chk(cmd_pos, fb_pos, "track fb");
    chk(32'(deviation_clear), 32'h1, "dev clear");
    cyc(25);
    chk(32'(alarm_state), 32'h0, "early alarm");
    cyc(30);
    chk(32'(alarm_state), 32'h1, "timeout alarm");
    rd(OFS_FLG, 32'h0000_000C, "flags tmo");
    clr("estop");
  endtask

  task automatic t_seqlow();
    for (int s = 0; s < 4; s++) begin
      cfg(32'(s), 32'h012C_0096, 32'h0, 32'h5, 32'h001E_0000);
      motor_speed <= 16'h03E8;
      pulse(1'b0);
      cyc(3);
      chk(32'(dynamic_brake), 32'(!s[0]), "mid brake");
      chk(32'(current_off), 32'h1, "cur off");
      chk(32'(torque_limit), 32'h12C, "no etrq");
      apb(1'b0, OFS_STA, 32'h0);
      chk(rd_q & 32'h7, 32'h3, "no estop");
      clr("seq low");
    end
  endtask

  task automatic t_zero();
    cfg(32'h5, 32'h012C_0096, 32'h0, 32'h0, 32'h001E_0000);
    motor_speed <= 16'h03E8;
    forced_alarm_pin <= 1'b1;
    cyc(8);
    forced_alarm_pin <= 1'b0;
    chk(32'(alarm_state), 32'h1, "zero tmo");
    chk(32'(torque_limit), 32'h12C, "no estop");
    clr("zero tmo");
  endtask

  task automatic t_abort();
    cfg(32'h6, 32'h012C_0096, 32'h0, 32'h14, 32'h001E_0000);
    motor_speed <= 16'h03E8;
    pulse(1'b0);
    cyc(3);
    chk(32'(torque_limit), 32'h096, "in estop");
    pulse(1'b1);
    cyc(3);
    chk(32'(alarm_state), 32'h1, "abort");
    chk(32'(current_off), 32'h1, "abort cur");
    chk(32'(dynamic_brake), 32'h1, "abort db");
    rd(OFS_FLG, 32'h0000_0018, "flags abort");
    clr("abort");
  endtask

  task automatic t_ovs();
    logic [31:0] osl [3] = '{32'h0BB8_07D0, 32'h0BB8_07D0, 32'h03E8_07D0};
    logic [15:0] spd [3] = '{16'h09C4, 16'h0FA0, 16'h05DC};
    logic [31:0] flg [3] = '{32'h1, 32'h3, 32'h2};
    logic [31:0] st  [3] = '{32'h2, 32'h3, 32'h3};
    for (int i = 0; i < 3; i++) begin
      cfg(32'h4, 32'h012C_0096, osl[i], 32'h5, 32'h001E_0000);
      motor_speed <= spd[i];
      cyc(6);
      apb(1'b0, OFS_STA, 32'h0);
      chk(rd_q & 32'h7, st[i], "ovs state");
      apb(1'b0, OFS_FLG, 32'h0);
      chk(rd_q & 32'h7, flg[i], "ovs flags");
      clr("overspeed");
    end
  endtask

  task automatic t_brk(input logic [31:0] brk, tmo, input int w1, w2,
                       input logic [15:0] sp2);
    cfg(32'h4, 32'h012C_0000, 32'h0, tmo, brk);
    motor_speed <= 16'h03E8;
    pulse(1'b0);
    cyc(w1);
    chk(32'(brake_release), 32'h1, "brake held");
    chk(32'(torque_limit), 32'h12C, "zero etrq");
    motor_speed <= sp2;
    cyc(w2);
    chk(32'(brake_release), 32'h0, "brake set");
    clr("brake");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, emg_alarm_in, nonemg_alarm_in} = 5'h00;
    forced_alarm_pin = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    motor_speed = 16'h0;
    fb_pos = 32'h0000_5A5A;
    host_en = 1'b1;
    rst_n = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(4);
    t_reset();
    t_estop();
    t_seqlow();
    t_zero();
    t_abort();
    t_ovs();
    t_brk(32'h001E_0002, 32'h5, 8, 15, 16'h03E8);
    t_brk(32'h001E_0008, 32'h3, 20, 20, 16'h03E8);
    t_brk(32'h01F4_0014, 32'h1E, 10, 3, 16'h0190);
    t_brk(32'h001E_0005, 32'h5, 8, 45, 16'h03E8);
    final_report();
  end
endmodule
